// ===== rtl/port_d_e_alternate_function_mux.sv
// Contract
// - Upper port-D pins carry data bus high bits only in wave/FIFO mode and word-wide.
// - Each port-E pin follows its own function-select bit: GPIO or alternate.
// - Timer-0 overflow pin pulses high one cycle per overflow, else low.
// - In split mode, timer overflow pulse comes from low-byte counter overflow.
// - Timer-1 overflow pin pulses high one cycle per overflow.
// - Timer-2 overflow pin pulses high one cycle per overflow.
// - Serial-0 pin carries data only in synchronous shift mode, else high.
// - Serial-1 pin carries data only in synchronous shift mode, else high.
// - Interrupt-6 request recognised on rising pin edge, active high.
// - Falling edge on reload input reloads timer 2 only when ext enable set.
// - Port-E pin 7 alternate drives waveform address bit 8.
// - FIFO mode: ready-0 is read strobe, polarity from polarity bit 3.
// - FIFO mode: ready-1 is write strobe, polarity from polarity bit 2.
// - Wave mode: ready-0..2 pins sampled as waveform ready inputs.
`default_nettype none
module port_d_e_alternate_function_mux
    import pin_mux_pkg::*;
(
    input  wire logic          hclk,
    input  wire logic          hresetn,
    input  wire logic          hsel,
    input  wire logic [7:0]    haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output logic               hreadyout,
    output logic               hresp,
    output logic      [31:0]   hrdata,
    input  wire logic [3:0]    portd_pin_in,
    output logic      [3:0]    portd_pin_out,
    output logic      [3:0]    portd_pin_oe,
    input  wire logic [7:0]    porte_pin_in,
    output logic      [7:0]    porte_pin_out,
    output logic      [7:0]    porte_pin_oe,
    input  wire logic [2:0]    ready_pin_in,
    input  wire logic [3:0]    iface_data_bus_hi_out,
    input  wire logic [3:0]    iface_data_bus_hi_oe,
    output logic      [3:0]    iface_data_bus_hi_in,
    input  wire timer_events_t timer_events,
    input  wire serial_out_t   serial0,
    input  wire serial_out_t   serial1,
    input  wire logic          wave_addr_bit8,
    output logic               ext_irq_six,
    output logic               timer2_reload,
    output logic               fifo_read_strobe,
    output logic               fifo_write_strobe,
    output logic      [2:0]    wave_ready
);

    logic [1:0]  interface_config_q;
    logic        endpoint_fifo_config_q;
    logic [7:0]  port_e_function_select_q;
    logic [3:0]  fifo_pin_polarity_q;
    logic [7:0]  timer2_control_q;
    logic [3:0]  portd_gpio_out_q;
    logic [3:0]  portd_gpio_oe_q;
    logic [7:0]  porte_gpio_out_q;
    logic [7:0]  porte_gpio_oe_q;
    logic [1:0]  event_flags_q;
    logic [1:0]  event_flags_d;
    logic        wr_pend_q;
    logic [7:0]  wr_addr_q;
    logic [31:0] rd_data;

    // Bus decode
    wire addr_phase = hsel & htrans[1] & hready;
    wire rd_take    = addr_phase & ~hwrite;
    wire wr_take    = addr_phase & hwrite;
    wire wr_now     = wr_pend_q & hready;
    wire wr_iface   = wr_now & (wr_addr_q == ADDR_IFACE_CFG);
    wire wr_ep      = wr_now & (wr_addr_q == ADDR_EP_CFG);
    wire wr_esel    = wr_now & (wr_addr_q == ADDR_PORTE_SEL);
    wire wr_pol     = wr_now & (wr_addr_q == ADDR_POLARITY);
    wire wr_t2      = wr_now & (wr_addr_q == ADDR_T2_CTRL);
    wire wr_dout    = wr_now & (wr_addr_q == ADDR_PORTD_OUT);
    wire wr_doe     = wr_now & (wr_addr_q == ADDR_PORTD_OE);
    wire wr_eout    = wr_now & (wr_addr_q == ADDR_PORTE_OUT);
    wire wr_eoe     = wr_now & (wr_addr_q == ADDR_PORTE_OE);
    wire wr_flags   = wr_now & (wr_addr_q == ADDR_EVENT_FLAGS);

    // Mode decode
    wire iface_mode_t mode   = iface_mode_t'(interface_config_q);
    wire fifo_mode           = (mode == MODE_FIFO);
    wire wave_mode           = (mode == MODE_WAVE);
    wire wide_en             = (fifo_mode | wave_mode) & endpoint_fifo_config_q;
    wire pol_rd              = fifo_pin_polarity_q[POL_READ_BIT];
    wire pol_wr              = fifo_pin_polarity_q[POL_WRITE_BIT];
    wire ext_en              = timer2_control_q[EXT_ENABLE_BIT];

    // Split mode takes the low-byte counter as the overflow source
    wire t0_pulse = timer_events.t0_split ? timer_events.t0_low_ovf : timer_events.t0_ovf;
    wire t1_pulse = timer_events.t1_split ? timer_events.t1_low_ovf : timer_events.t1_ovf;
    wire s0_pin   = (serial0.mode == SER_SYNC_MODE) ? serial0.data : 1'b1;
    wire s1_pin   = (serial1.mode == SER_SYNC_MODE) ? serial1.data : 1'b1;

    // Alternate output values and enables; pins 5 and 6 are inputs
    wire [7:0] alt_out = {wave_addr_bit8, 2'b00, s1_pin, s0_pin, timer_events.t2_ovf, t1_pulse, t0_pulse};
    wire [7:0] alt_oe  = 8'h9f;

    logic [7:0] pe_out_d;
    logic [7:0] pe_oe_d;
    logic [3:0] pd_out_d;
    logic [3:0] pd_oe_d;
    logic [1:0] edge_rise;
    logic [1:0] edge_fall;

    genvar k;
    generate
        for (k = 0; k < 8; k++)
        begin : g_porte
            assign pe_out_d[k] = port_e_function_select_q[k] ? alt_out[k] : porte_gpio_out_q[k];
            assign pe_oe_d[k]  = port_e_function_select_q[k] ? alt_oe[k] : porte_gpio_oe_q[k];
        end
        for (k = 0; k < 4; k++)
        begin : g_portd
            assign pd_out_d[k] = wide_en ? iface_data_bus_hi_out[k] : portd_gpio_out_q[k];
            assign pd_oe_d[k]  = wide_en ? iface_data_bus_hi_oe[k] : portd_gpio_oe_q[k];
        end
    endgenerate

    pin_edge_detect #(.W(2)) u_edges
    (
        .hclk    (hclk),
        .hresetn (hresetn),
        .level   ({porte_pin_in[PE_TIMER2_EXT_RELOAD_IN], porte_pin_in[PE_IRQ]}),
        .rise    (edge_rise),
        .fall    (edge_fall)
    );

    wire irq_evt    = port_e_function_select_q[PE_IRQ] & edge_rise[0];
    wire reload_evt = port_e_function_select_q[PE_TIMER2_EXT_RELOAD_IN] & edge_fall[1] & ext_en;

    // Strobes are normalised to active high; polarity bit set means active high
    wire rd_strobe_d = fifo_mode & ~(ready_pin_in[0] ^ pol_rd);
    wire wr_strobe_d = fifo_mode & ~(ready_pin_in[1] ^ pol_wr);

    // Set wins over a write-one-to-clear in the same cycle
    always_comb
    begin
        event_flags_d = event_flags_q;
        if (wr_flags)
            event_flags_d = event_flags_q & ~hwdata[1:0];
        if (irq_evt)
            event_flags_d[FLAG_IRQ_BIT] = 1'b1;
        if (reload_evt)
            event_flags_d[FLAG_RELOAD_BIT] = 1'b1;
    end

    assign rd_data =
        (haddr == ADDR_IFACE_CFG)   ? {30'h0, interface_config_q} :
        (haddr == ADDR_EP_CFG)      ? {31'h0, endpoint_fifo_config_q} :
        (haddr == ADDR_PORTE_SEL)   ? {24'h0, port_e_function_select_q} :
        (haddr == ADDR_POLARITY)    ? {28'h0, fifo_pin_polarity_q} :
        (haddr == ADDR_T2_CTRL)     ? {24'h0, timer2_control_q} :
        (haddr == ADDR_PORTD_OUT)   ? {28'h0, portd_gpio_out_q} :
        (haddr == ADDR_PORTD_OE)    ? {28'h0, portd_gpio_oe_q} :
        (haddr == ADDR_PORTE_OUT)   ? {24'h0, porte_gpio_out_q} :
        (haddr == ADDR_PORTE_OE)    ? {24'h0, porte_gpio_oe_q} :
        (haddr == ADDR_PIN_STATUS)  ? {20'h0, portd_pin_in, porte_pin_in} :
        (haddr == ADDR_EVENT_FLAGS) ? {30'h0, event_flags_q} : 32'h0;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= RST_BYTE;
            hrdata    <= 32'h0;
            hreadyout <= RST_HREADY;
            hresp     <= 1'b0;
        end
        else
        begin
            wr_pend_q <= wr_take;
            if (wr_take)
                wr_addr_q <= haddr;
            if (rd_take)
                hrdata <= rd_data;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            interface_config_q       <= RST_MODE;
            endpoint_fifo_config_q   <= 1'b0;
            port_e_function_select_q <= RST_BYTE;
            fifo_pin_polarity_q      <= RST_NIBBLE;
            timer2_control_q         <= RST_BYTE;
            portd_gpio_out_q         <= RST_NIBBLE;
            portd_gpio_oe_q          <= RST_NIBBLE;
            porte_gpio_out_q         <= RST_BYTE;
            porte_gpio_oe_q          <= RST_BYTE;
            event_flags_q            <= 2'h0;
        end
        else
        begin
            if (wr_iface)
                interface_config_q <= hwdata[MODE_LSB +: 2];
            if (wr_ep)
                endpoint_fifo_config_q <= hwdata[WORDWIDE_BIT];
            if (wr_esel)
                port_e_function_select_q <= hwdata[7:0];
            if (wr_pol)
                fifo_pin_polarity_q <= hwdata[3:0];
            if (wr_t2)
                timer2_control_q <= hwdata[7:0];
            if (wr_dout)
                portd_gpio_out_q <= hwdata[3:0];
            if (wr_doe)
                portd_gpio_oe_q <= hwdata[3:0];
            if (wr_eout)
                porte_gpio_out_q <= hwdata[7:0];
            if (wr_eoe)
                porte_gpio_oe_q <= hwdata[7:0];
            event_flags_q <= event_flags_d;
        end
    end

    // All pin enables clear on reset so the pins float and come up as inputs
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            porte_pin_out        <= RST_BYTE;
            porte_pin_oe         <= RST_BYTE;
            portd_pin_out        <= RST_NIBBLE;
            portd_pin_oe         <= RST_NIBBLE;
            iface_data_bus_hi_in <= RST_NIBBLE;
            ext_irq_six          <= 1'b0;
            timer2_reload        <= 1'b0;
            fifo_read_strobe     <= 1'b0;
            fifo_write_strobe    <= 1'b0;
            wave_ready           <= 3'h0;
        end
        else
        begin
            porte_pin_out        <= pe_out_d;
            porte_pin_oe         <= pe_oe_d;
            portd_pin_out        <= pd_out_d;
            portd_pin_oe         <= pd_oe_d;
            iface_data_bus_hi_in <= wide_en ? portd_pin_in : RST_NIBBLE;
            ext_irq_six          <= irq_evt;
            timer2_reload        <= reload_evt;
            fifo_read_strobe     <= rd_strobe_d;
            fifo_write_strobe    <= wr_strobe_d;
            wave_ready           <= wave_mode ? ready_pin_in : 3'h0;
        end
    end

    sequence s_irq_rise;
        port_e_function_select_q[PE_IRQ] && !porte_pin_in[PE_IRQ] ##1 porte_pin_in[PE_IRQ];
    endsequence

    sequence s_reload_fall;
        porte_pin_in[PE_TIMER2_EXT_RELOAD_IN] ##1 !porte_pin_in[PE_TIMER2_EXT_RELOAD_IN] && ext_en && port_e_function_select_q[PE_TIMER2_EXT_RELOAD_IN];
    endsequence

    a_fd_high_route: assert property (@(posedge hclk) disable iff (!hresetn)
        wide_en |=> portd_pin_oe == $past(iface_data_bus_hi_oe) && portd_pin_out == $past(iface_data_bus_hi_out))
        else $error("upper port D not routed to data bus");
    a_fd_gpio_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        !wide_en |=> portd_pin_oe == $past(portd_gpio_oe_q))
        else $error("upper port D left gpio");
    a_pe_gpio_sel: assert property (@(posedge hclk) disable iff (!hresetn)
        !port_e_function_select_q[PE_WADR] |=> porte_pin_out[PE_WADR] == $past(porte_gpio_out_q[PE_WADR]))
        else $error("port E pin 7 gpio not honoured");
    a_t0_pulse_one: assert property (@(posedge hclk) disable iff (!hresetn)
        port_e_function_select_q[PE_T0] && !timer_events.t0_split ##0 timer_events.t0_ovf
        ##1 !timer_events.t0_ovf && !timer_events.t0_split && port_e_function_select_q[PE_T0]
        |-> porte_pin_out[PE_T0] ##1 !porte_pin_out[PE_T0] || !port_e_function_select_q[PE_T0])
        else $error("timer 0 pulse not one cycle");
    a_t0_split_src: assert property (@(posedge hclk) disable iff (!hresetn)
        port_e_function_select_q[PE_T0] && timer_events.t0_split |=> porte_pin_out[PE_T0] == $past(timer_events.t0_low_ovf))
        else $error("timer 0 split source wrong");
    a_t1_pulse_on: assert property (@(posedge hclk) disable iff (!hresetn)
        port_e_function_select_q[PE_T1] && !timer_events.t1_split && timer_events.t1_ovf |=> porte_pin_out[PE_T1])
        else $error("timer 1 pulse missing");
    a_t2_pulse_on: assert property (@(posedge hclk) disable iff (!hresetn)
        port_e_function_select_q[PE_T2] |=> porte_pin_out[PE_T2] == $past(timer_events.t2_ovf))
        else $error("timer 2 pulse wrong");
    a_ser0_idle_high: assert property (@(posedge hclk) disable iff (!hresetn)
        port_e_function_select_q[PE_SER0] && serial0.mode != SER_SYNC_MODE |=> porte_pin_out[PE_SER0])
        else $error("serial 0 pin not high");
    a_ser1_sync_data: assert property (@(posedge hclk) disable iff (!hresetn)
        port_e_function_select_q[PE_SER1] |=> porte_pin_out[PE_SER1] == ($past(serial1.mode) == SER_SYNC_MODE ?
        $past(serial1.data) : 1'b1))
        else $error("serial 1 pin wrong");
    a_irq_on_rise: assert property (@(posedge hclk) disable iff (!hresetn)
        s_irq_rise ##0 port_e_function_select_q[PE_IRQ] |=> ext_irq_six ##1 !ext_irq_six || $past(irq_evt))
        else $error("interrupt 6 edge missed");
    a_reload_gated: assert property (@(posedge hclk) disable iff (!hresetn)
        timer2_reload |-> $past(ext_en) && $past(porte_pin_in[PE_TIMER2_EXT_RELOAD_IN], 2) && !$past(porte_pin_in[PE_TIMER2_EXT_RELOAD_IN]))
        else $error("timer 2 reload without cause");
    a_reload_fires: assert property (@(posedge hclk) disable iff (!hresetn)
        s_reload_fall |=> timer2_reload)
        else $error("timer 2 reload missed");
    a_wave_addr_pin: assert property (@(posedge hclk) disable iff (!hresetn)
        port_e_function_select_q[PE_WADR] |=> porte_pin_oe[PE_WADR] && porte_pin_out[PE_WADR] == $past(wave_addr_bit8))
        else $error("wave address bit not driven");
    a_read_strobe: assert property (@(posedge hclk) disable iff (!hresetn)
        fifo_mode |=> fifo_read_strobe == ($past(ready_pin_in[0]) == $past(pol_rd)))
        else $error("read strobe polarity wrong");
    a_write_strobe: assert property (@(posedge hclk) disable iff (!hresetn)
        fifo_write_strobe |-> $past(fifo_mode) && ($past(ready_pin_in[1]) == $past(pol_wr)))
        else $error("write strobe without cause");
    a_wave_ready: assert property (@(posedge hclk) disable iff (!hresetn)
        wave_mode |=> wave_ready == $past(ready_pin_in))
        else $error("wave ready not sampled");
    a_reset_float: assert property (@(posedge hclk)
        !hresetn |=> hresetn || (porte_pin_oe == 8'h00 && portd_pin_oe == 4'h0))
        else $error("pins driven in reset");

endmodule
`default_nettype wire

// ===== rtl/pin_mux_pkg.sv
`default_nettype none
package pin_mux_pkg;

    // Register byte offsets
    localparam logic [7:0] ADDR_IFACE_CFG   = 8'h00;
    localparam logic [7:0] ADDR_EP_CFG      = 8'h04;
    localparam logic [7:0] ADDR_PORTE_SEL   = 8'h08;
    localparam logic [7:0] ADDR_POLARITY    = 8'h0c;
    localparam logic [7:0] ADDR_T2_CTRL     = 8'h10;
    localparam logic [7:0] ADDR_PORTD_OUT   = 8'h14;
    localparam logic [7:0] ADDR_PORTD_OE    = 8'h18;
    localparam logic [7:0] ADDR_PORTE_OUT   = 8'h1c;
    localparam logic [7:0] ADDR_PORTE_OE    = 8'h20;
    localparam logic [7:0] ADDR_PIN_STATUS  = 8'h24;
    localparam logic [7:0] ADDR_EVENT_FLAGS = 8'h28;

    // Field positions
    localparam int MODE_LSB        = 0;
    localparam int WORDWIDE_BIT    = 0;
    localparam int POL_READ_BIT    = 3;
    localparam int POL_WRITE_BIT   = 2;
    localparam int EXT_ENABLE_BIT  = 3;
    localparam int FLAG_IRQ_BIT    = 0;
    localparam int FLAG_RELOAD_BIT = 1;

    // Port E pin roles
    localparam int PE_T0   = 0;
    localparam int PE_T1   = 1;
    localparam int PE_T2   = 2;
    localparam int PE_SER0 = 3;
    localparam int PE_SER1 = 4;
    localparam int PE_IRQ  = 5;
    localparam int PE_TIMER2_EXT_RELOAD_IN = 6;
    localparam int PE_WADR = 7;

    // Reset values
    localparam logic [1:0] RST_MODE     = 2'h0;
    localparam logic [7:0] RST_BYTE     = 8'h00;
    localparam logic [3:0] RST_NIBBLE   = 4'h0;
    localparam logic       RST_HREADY   = 1'b1;

    // Serial mode that shifts synchronously
    localparam logic [1:0] SER_SYNC_MODE = 2'h0;

    typedef enum logic [1:0]
    {
        MODE_PORTS = 2'h0,
        MODE_RSVD  = 2'h1,
        MODE_WAVE  = 2'h2,
        MODE_FIFO  = 2'h3
    } iface_mode_t;

    typedef struct packed
    {
        logic t0_ovf;
        logic t0_split;
        logic t0_low_ovf;
        logic t1_ovf;
        logic t1_split;
        logic t1_low_ovf;
        logic t2_ovf;
    } timer_events_t;

    typedef struct packed
    {
        logic [1:0] mode;
        logic       data;
    } serial_out_t;

endpackage
`default_nettype wire

// ===== rtl/pin_edge_detect.sv
`default_nettype none
module pin_edge_detect
#(
    parameter int W = 2
)
(
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic [W-1:0] level,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);

    logic [W-1:0] prev_q;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            prev_q <= '0;
        else
            prev_q <= level;
    end

    // Pins are synchronous to hclk, so one stage of history suffices
    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_edge
            assign rise[i] = level[i] & ~prev_q[i];
            assign fall[i] = ~level[i] & prev_q[i];
        end
    endgenerate

endmodule
`default_nettype wire

// ===== tb/fifo_master_model.sv
`default_nettype none
module fifo_master_model
(
    input  wire logic       rd_req,
    input  wire logic       wr_req,
    input  wire logic       wave_ready_2_lvl,
    input  wire logic [3:0] polarity,
    input  wire logic [3:0] d_ext,
    input  wire logic [7:0] e_ext,
    input  wire logic [3:0] d_out,
    input  wire logic [3:0] d_oe,
    input  wire logic [7:0] e_out,
    input  wire logic [7:0] e_oe,
    output logic      [2:0] ready_pin,
    output logic      [3:0] d_pin,
    output logic      [7:0] e_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int POL_RD = 3;
    localparam int POL_WR = 2;
    // Strobe requests are active high; the pin level follows the configured polarity
    assign ready_pin[0] = polarity[POL_RD] ? rd_req : ~rd_req;
    assign ready_pin[1] = polarity[POL_WR] ? wr_req : ~wr_req;
    assign ready_pin[2] = wave_ready_2_lvl;
    // Released lines take a fresh random level every cycle so a stale value never passes
    assign d_pin = (d_oe & d_out) | (~d_oe & d_ext);
    assign e_pin = (e_oe & e_out) | (~e_oe & e_ext);
endmodule
`default_nettype wire

// ===== tb/port_d_e_alternate_function_mux_tb.sv
`default_nettype none
module port_d_e_alternate_function_mux_tb
    import pin_mux_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic          hclk = 1'b0;
    logic          hresetn = 1'b0;
    logic          hsel = 1'b0;
    logic [7:0]    haddr = 8'h00;
    logic [1:0]    htrans = 2'h0;
    logic          hwrite = 1'b0;
    logic [2:0]    hsize = 3'h2;
    logic [31:0]   hwdata = 32'h0;
    logic          hreadyout, hresp, irq, reload, rstb, wstb;
    logic [31:0]   hrdata;
    logic [3:0]    d_pin, d_out, d_oe, d_hi_in, x_dout, x_doe, x_dhi;
    logic [7:0]    e_pin, e_out, e_oe, x_eout, x_eoe;
    logic [2:0]    rdy, wave_ready, x_wr;
    logic [3:0]    hi_out = 4'h0, hi_oe = 4'h0, d_ext = 4'h0;
    logic [7:0]    e_ext = 8'h00;
    timer_events_t tev = '0;
    serial_out_t   ser0 = '0, ser1 = '0;
    logic          wab8 = 1'b0, rd_req = 1'b0, wr_req = 1'b0, wave_ready_2 = 1'b0;
    logic          live = 1'b0, cmp = 1'b0, clr_q = 1'b0, p5, p6, x_irq, x_rel, x_rs, x_ws;
    logic [1:0]    flg = 2'h0;
    logic [31:0]   snap = 32'h0;
    logic [31:0]   sh [9] = '{default: 32'h0};
    int            errors = 0, checked = 0;

    wire logic [1:0] mode = sh[0][1:0];
    wire logic       route = (mode == MODE_WAVE || mode == MODE_FIFO) && sh[1][WORDWIDE_BIT];
    wire logic [7:0] sel = sh[2][7:0];
    wire logic       t0 = tev.t0_split ? tev.t0_low_ovf : tev.t0_ovf;
    wire logic       t1 = tev.t1_split ? tev.t1_low_ovf : tev.t1_ovf;
    wire logic       s0 = (ser0.mode == SER_SYNC_MODE) ? ser0.data : 1'b1;
    wire logic       s1 = (ser1.mode == SER_SYNC_MODE) ? ser1.data : 1'b1;
    wire logic [7:0] alt = {wab8, 2'b00, s1, s0, tev.t2_ovf, t1, t0};
    // Edge events of this cycle: pin level now against the level one edge ago
    wire logic [1:0] ev = {sel[PE_TIMER2_EXT_RELOAD_IN] & sh[4][EXT_ENABLE_BIT] & ~e_pin[PE_TIMER2_EXT_RELOAD_IN] & p6,
                           sel[PE_IRQ] & e_pin[PE_IRQ] & ~p5};

    port_d_e_alternate_function_mux i_port_d_e_alternate_function_mux
    (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .portd_pin_in(d_pin), .portd_pin_out(d_out), .portd_pin_oe(d_oe),
        .porte_pin_in(e_pin), .porte_pin_out(e_out), .porte_pin_oe(e_oe), .ready_pin_in(rdy),
        .iface_data_bus_hi_out(hi_out), .iface_data_bus_hi_oe(hi_oe), .iface_data_bus_hi_in(d_hi_in),
        .timer_events(tev), .serial0(ser0), .serial1(ser1), .wave_addr_bit8(wab8),
        .ext_irq_six(irq), .timer2_reload(reload), .fifo_read_strobe(rstb),
        .fifo_write_strobe(wstb), .wave_ready(wave_ready)
    );

    fifo_master_model i_fifo_master_model
    (
        .rd_req(rd_req), .wr_req(wr_req), .wave_ready_2_lvl(wave_ready_2), .polarity(sh[3][3:0]),
        .d_ext(d_ext), .e_ext(e_ext), .d_out(d_out), .d_oe(d_oe), .e_out(e_out), .e_oe(e_oe),
        .ready_pin(rdy), .d_pin(d_pin), .e_pin(e_pin)
    );

    initial
    begin
        forever #20 hclk = ~hclk;
    end

    always @(posedge hclk)
        if (hresetn)
        begin
            tev <= timer_events_t'($urandom);
            ser0 <= serial_out_t'($urandom);
            ser1 <= serial_out_t'($urandom);
            {wab8, rd_req, wr_req, wave_ready_2} <= 4'($urandom);
            {hi_out, hi_oe, d_ext, e_ext} <= 20'($urandom);
        end

    // Reference: each output is the mux of what was seen at the previous edge
    always @(posedge hclk)
    begin
        {p5, p6} <= {e_pin[PE_IRQ], e_pin[PE_TIMER2_EXT_RELOAD_IN]};
        cmp <= live;
        x_dout <= route ? hi_out : sh[5][3:0];
        x_doe <= route ? hi_oe : sh[6][3:0];
        x_dhi <= route ? d_pin : 4'h0;
        x_eout <= (sel & alt) | (~sel & sh[7][7:0]);
        x_eoe <= (sel & 8'h9f) | (~sel & sh[8][7:0]);
        x_irq <= ev[0];
        x_rel <= ev[1];
        x_rs <= (mode == MODE_FIFO) & rd_req;
        x_ws <= (mode == MODE_FIFO) & wr_req;
        x_wr <= (mode == MODE_WAVE) ? rdy : 3'h0;
        // Flag model: a clear lands in the data phase, and an event in that cycle still sets
        clr_q <= hsel & htrans[1] & hwrite & (haddr == ADDR_EVENT_FLAGS);
        flg <= (flg & ~(clr_q ? hwdata[1:0] : 2'h0)) | ev;
        if (hsel & htrans[1] & ~hwrite)
            snap <= (haddr == ADDR_EVENT_FLAGS) ? 32'(flg) : {20'h0, d_pin, e_pin};
    end

    always @(negedge hclk)
        if (cmp)
        begin
            chk(32'(d_oe), 32'(x_doe));
            chk(32'(d_out & x_doe), 32'(x_dout & x_doe));
            chk(32'(d_hi_in), 32'(x_dhi));
            chk(32'(e_oe), 32'(x_eoe));
            chk(32'(e_out & x_eoe), 32'(x_eout & x_eoe));
            chk(32'(irq), 32'(x_irq));
            chk(32'(reload), 32'(x_rel));
            chk(32'({rstb, wstb}), 32'({x_rs, x_ws}));
            chk(32'(wave_ready), 32'(x_wr));
        end

    function automatic logic [31:0] mask(input logic [5:0] i);
        case (i)
            6'h0: return 32'h3;
            6'h1: return 32'h1;
            6'h3, 6'h5, 6'h6: return 32'hf;
            default: return 32'hff;
        endcase
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        checked++;
        if (seen !== want)
        begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    // Comparison pauses while a write settles; the mux lags the register by a cycle
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] unused;
        live <= 1'b0;
        ahb(1'b1, a, d, unused);
        if (a[7:2] < 9)
            sh[a[7:2]] <= d & mask(a[7:2]);
        repeat (3) @(posedge hclk);
        live <= 1'b1;
    endtask

    task automatic close_out();
        if (errors == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge hclk);
        errors++;
        close_out();
    end

    initial
    begin
        logic [31:0] v;
        void'($urandom(85));
        repeat (3) @(posedge hclk);
        chk(32'({d_oe, e_oe}), 32'h0);
        chk(32'({hreadyout, hresp}), 32'h2);
        hresetn <= 1'b1;
        for (int i = 0; i < 10; i++)
        begin
            ahb(1'b0, (i == 9) ? 8'h2c : 8'(i * 4), 32'h0, v);
            chk(v, 32'h0);
        end
        for (int i = 0; i < 40; i++)
        begin
            for (int r = 0; r < 9; r++)
            begin
                v = $urandom;
                if (r == 0)
                    v = 32'(i % 4);
                if (r == 1)
                    v = 32'((i >> 2) & 1);
                if (r == 2 && i < 2)
                    v = i ? 32'hff : 32'h0;
                if (r == 3)
                    v = 32'((i >> 3) << 2);
                wr(8'(r * 4), v);
                ahb(1'b0, 8'(r * 4), 32'h0, v);
                chk(v, sh[r]);
            end
            for (int a = 9; a < 11; a++)
            begin
                ahb(1'b0, 8'(a * 4), 32'h0, v);
                chk(v, snap);
            end
            wr(ADDR_EVENT_FLAGS, 32'(i % 4));
            repeat (30) @(posedge hclk);
        end
        wr(8'h2c, 32'hffffffff);
        ahb(1'b0, 8'h2c, 32'h0, v);
        chk(v, 32'h0);
        close_out();
    end
endmodule
`default_nettype wire
